// ===== hdl/post_reset_init_sequencer.sv
// post-reset init sequencer, master end of the link
`timescale 1ns/1ns
// Operation
// - steps run boot, clock, pins, power, system, enables, priorities, cache, old request count
// - reprogram clock only if frequency differs
// - hold ethernet in reset before pin selects
// - write I/O power-down after pin selection
// - system registers written only when peripherals idle
// - host port control only if timeout wanted
// - timer control only for timer0, watchdog
// - leave DMA transfer config at default
// - priorities after power enable, peripherals idle
// - master priorities accepted before or after enable
// - queue and arbitration priority after power enable
// - cache mode 0 off, 1-3 4/8/16 kB
// - cache mode: write, read, write, read
// - cache config read stalls until change done
// - boot leaves all cache modes at zero
// - application enables caches itself after boot
// - old request count set to 0x20
module post_reset_init_sequencer (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // link
  cfg_link_if.master link,
  // orders
  input wire logic start,
  input wire logic [31:0] desired_clk,
  input wire logic use_ethernet,
  input wire logic [31:0] pin_sel0,
  input wire logic [31:0] pin_sel1,
  input wire logic [31:0] io_pwdn,
  input wire logic host_port_en,
  input wire logic [31:0] host_port_val,
  input wire logic timer_en,
  input wire logic [31:0] timer_val,
  input wire logic [31:0] power_enable_val,
  input wire logic [31:0] mst_pri0,
  input wire logic [31:0] mst_pri1,
  input wire logic [31:0] que_pri,
  input wire logic [31:0] core_arb_pri,
  input wire logic [1:0] pcache_mode,
  // status
  output logic busy,
  output logic done,
  output logic bus_error,
  output logic [4:0] step
);
  localparam logic [4:0] LAST_STEP = 5'd19;

  typedef enum logic [2:0] {S_IDLE, S_NEXT, S_WRITE, S_READ, S_DONE} seq_e;

  seq_e state_reg, state_next;
  logic [4:0] step_reg, step_next;
  logic awvalid_reg, awvalid_next, wvalid_reg, wvalid_next, bready_reg, bready_next;
  logic arvalid_reg, arvalid_next, rready_reg, rready_next;
  logic [7:0] addr_reg, addr_next;
  logic [31:0] data_reg, data_next, rd_last_reg, rd_last_next;
  logic err_reg, err_next;
  init_seq_pkg::op_e op_kind;
  logic [7:0] op_addr;
  logic [31:0] op_data, poll_mask, poll_val;
  logic op_en;

  // step table in the documented order
  always_comb begin
    op_kind = init_seq_pkg::OP_WR;
    op_addr = init_seq_pkg::OFS_BOOT_STATUS;
    op_data = 32'h0000_0000;
    op_en = 1'b1;
    poll_mask = 32'h0000_0000;
    poll_val = 32'h0000_0000;
    unique case (step_reg)
      5'd0: begin
        op_kind = init_seq_pkg::OP_POLL;
        poll_mask = 32'h0000_0001;
        poll_val = 32'h0000_0001;
      end
      5'd1: begin
        op_kind = init_seq_pkg::OP_RD;
        op_addr = init_seq_pkg::OFS_CLK_CTRL;
      end
      5'd2: begin
        op_addr = init_seq_pkg::OFS_CLK_CTRL;
        op_data = desired_clk;
        op_en = (rd_last_reg != desired_clk);
      end
      5'd3: begin
        op_addr = init_seq_pkg::OFS_ETH_RESET;
        op_data = 32'h0000_0001;
        op_en = use_ethernet;
      end
      5'd4: begin
        op_addr = init_seq_pkg::OFS_PIN_SEL0;
        op_data = pin_sel0;
      end
      5'd5: begin
        op_addr = init_seq_pkg::OFS_PIN_SEL1;
        op_data = pin_sel1;
      end
      5'd6: begin
        op_addr = init_seq_pkg::OFS_IO_PWDN;
        op_data = io_pwdn;
      end
      5'd7, 5'd11: begin
        op_kind = init_seq_pkg::OP_POLL;
        op_addr = init_seq_pkg::OFS_ACTIVITY;
        poll_mask = 32'hffff_ffff;
      end
      5'd8: begin
        op_addr = init_seq_pkg::OFS_HOST_PORT;
        op_data = host_port_val;
        op_en = host_port_en;
      end
      5'd9: begin
        op_addr = init_seq_pkg::OFS_TIMER;
        op_data = timer_val;
        op_en = timer_en;
      end
      5'd10: begin
        // the DMA transfer config is never written
        op_addr = init_seq_pkg::OFS_PWR_ENABLE;
        op_data = power_enable_val;
      end
      5'd12: begin
        op_addr = init_seq_pkg::OFS_MST_PRI0;
        op_data = mst_pri0;
      end
      5'd13: begin
        op_addr = init_seq_pkg::OFS_MST_PRI1;
        op_data = mst_pri1;
      end
      5'd14: begin
        op_addr = init_seq_pkg::OFS_DMA_QUE_PRI;
        op_data = que_pri;
      end
      5'd15: begin
        op_addr = init_seq_pkg::OFS_CORE_ARB;
        op_data = core_arb_pri;
      end
      5'd16, 5'd18: begin
        op_addr = init_seq_pkg::OFS_PCACHE_CFG;
        op_data = 32'(pcache_mode) << init_seq_pkg::PCACHE_MODE_LSB;
      end
      5'd17, 5'd19: begin
        op_kind = init_seq_pkg::OP_RD;
        op_addr = init_seq_pkg::OFS_PCACHE_CFG;
      end
      default: begin
        op_addr = init_seq_pkg::OFS_MEM_BURST;
        op_data = 32'(init_seq_pkg::OLD_COUNT_REC) << init_seq_pkg::OLD_COUNT_LSB;
      end
    endcase
  end

  always_comb begin
    state_next = state_reg;
    step_next = step_reg;
    awvalid_next = awvalid_reg;
    wvalid_next = wvalid_reg;
    bready_next = bready_reg;
    arvalid_next = arvalid_reg;
    rready_next = rready_reg;
    addr_next = addr_reg;
    data_next = data_reg;
    rd_last_next = rd_last_reg;
    err_next = err_reg;
    unique case (state_reg)
      S_IDLE, S_DONE: begin
        if (start) begin
          state_next = S_NEXT;
          step_next = 5'd0;
          err_next = 1'b0;
        end
      end
      S_NEXT: begin
        if (step_reg > LAST_STEP + 5'd1) begin
          state_next = S_DONE;
        end else if (!op_en) begin
          step_next = step_reg + 5'd1;
        end else begin
          addr_next = op_addr;
          data_next = op_data;
          if (op_kind == init_seq_pkg::OP_WR) begin
            awvalid_next = 1'b1;
            wvalid_next = 1'b1;
            bready_next = 1'b1;
            state_next = S_WRITE;
          end else begin
            arvalid_next = 1'b1;
            rready_next = 1'b1;
            state_next = S_READ;
          end
        end
      end
      S_WRITE: begin
        if (awvalid_reg && link.awready) awvalid_next = 1'b0;
        if (wvalid_reg && link.wready) wvalid_next = 1'b0;
        if (link.bvalid) begin
          bready_next = 1'b0;
          err_next = err_reg | (link.bresp != init_seq_pkg::RESP_OKAY);
          step_next = step_reg + 5'd1;
          state_next = S_NEXT;
        end
      end
      S_READ: begin
        if (arvalid_reg && link.arready) arvalid_next = 1'b0;
        if (link.rvalid) begin
          rready_next = 1'b0;
          rd_last_next = link.rdata;
          err_next = err_reg | (link.rresp != init_seq_pkg::RESP_OKAY);
          if (op_kind != init_seq_pkg::OP_POLL || (link.rdata & poll_mask) == poll_val) begin
            step_next = step_reg + 5'd1;
          end
          state_next = S_NEXT;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= S_IDLE;
      step_reg <= 5'd0;
      awvalid_reg <= 1'b0;
      wvalid_reg <= 1'b0;
      bready_reg <= 1'b0;
      arvalid_reg <= 1'b0;
      rready_reg <= 1'b0;
      addr_reg <= 8'h00;
      data_reg <= 32'h0000_0000;
      rd_last_reg <= 32'h0000_0000;
      err_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      step_reg <= step_next;
      awvalid_reg <= awvalid_next;
      wvalid_reg <= wvalid_next;
      bready_reg <= bready_next;
      arvalid_reg <= arvalid_next;
      rready_reg <= rready_next;
      addr_reg <= addr_next;
      data_reg <= data_next;
      rd_last_reg <= rd_last_next;
      err_reg <= err_next;
    end
  end

  assign link.awvalid = awvalid_reg;
  assign link.awaddr = addr_reg;
  assign link.wvalid = wvalid_reg;
  assign link.wdata = data_reg;
  assign link.wstrb = 4'hf;
  assign link.bready = bready_reg;
  assign link.arvalid = arvalid_reg;
  assign link.araddr = addr_reg;
  assign link.rready = rready_reg;
  assign busy = (state_reg != S_IDLE) && (state_reg != S_DONE);
  assign done = (state_reg == S_DONE);
  assign bus_error = err_reg;
  assign step = step_reg;
endmodule : post_reset_init_sequencer

// ===== hdl/init_seq_pkg.sv
// shared constants for the post-reset init sequencer and the configuration space
package init_seq_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CLK_PERIOD_NS = 40;
  // boot code run time and program cache mode change time
  localparam int BOOT_TIME_NS = 2000;
  localparam int BOOT_CYCLES = (BOOT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PCACHE_CHG_NS = 400;
  localparam int PCACHE_CHG_CYCLES = (PCACHE_CHG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // register byte offsets
  localparam logic [7:0] OFS_BOOT_STATUS = 8'h00;
  localparam logic [7:0] OFS_CLK_CTRL = 8'h04;
  localparam logic [7:0] OFS_ETH_RESET = 8'h08;
  localparam logic [7:0] OFS_PIN_SEL0 = 8'h0c;
  localparam logic [7:0] OFS_PIN_SEL1 = 8'h10;
  localparam logic [7:0] OFS_IO_PWDN = 8'h14;
  localparam logic [7:0] OFS_HOST_PORT = 8'h18;
  localparam logic [7:0] OFS_TIMER = 8'h1c;
  localparam logic [7:0] OFS_DMA_TC_CFG = 8'h20;
  localparam logic [7:0] OFS_PWR_ENABLE = 8'h24;
  localparam logic [7:0] OFS_ACTIVITY = 8'h28;
  localparam logic [7:0] OFS_MST_PRI0 = 8'h2c;
  localparam logic [7:0] OFS_MST_PRI1 = 8'h30;
  localparam logic [7:0] OFS_DMA_QUE_PRI = 8'h34;
  localparam logic [7:0] OFS_CORE_ARB = 8'h38;
  localparam logic [7:0] OFS_PCACHE_CFG = 8'h3c;
  localparam logic [7:0] OFS_DCACHE_CFG = 8'h40;
  localparam logic [7:0] OFS_L2_CFG = 8'h44;
  localparam logic [7:0] OFS_MEM_BURST = 8'h48;
  localparam logic [7:0] OFS_BOOT_ADDR = 8'h4c;
  localparam int NUM_REGS = 20;
  // reset values
  localparam logic [31:0] RST_CLK_CTRL = 32'h0000_0001;
  localparam logic [31:0] RST_IO_PWDN = 32'h0000_ffff;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  // fields
  localparam int PCACHE_MODE_LSB = 0;
  localparam int OLD_COUNT_LSB = 0;
  localparam logic [7:0] OLD_COUNT_REC = 8'h20;
  localparam logic [31:0] BOOT_DEFAULT_ADDR = 32'h0010_0000;
  localparam logic [3:0] BOOT_DIRECT_MODE = 4'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {OP_WR, OP_RD, OP_POLL} op_e;
endpackage : init_seq_pkg

// ===== hdl/cfg_link_if.sv
// register link between the init sequencer and the configuration space
`timescale 1ns/1ns
interface cfg_link_if;
  logic awvalid;
  logic awready;
  logic [7:0] awaddr;
  logic wvalid;
  logic wready;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic bvalid;
  logic bready;
  logic [1:0] bresp;
  logic arvalid;
  logic arready;
  logic [7:0] araddr;
  logic rvalid;
  logic rready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  modport master (
    output awvalid, awaddr, wvalid, wdata, wstrb, bready, arvalid, araddr, rready,
    input awready, wready, bvalid, bresp, arready, rvalid, rdata, rresp
  );
  modport slave (
    input awvalid, awaddr, wvalid, wdata, wstrb, bready, arvalid, araddr, rready,
    output awready, wready, bvalid, bresp, arready, rvalid, rdata, rresp
  );
endinterface : cfg_link_if

// ===== hdl/cfg_space_dev.sv
// configuration register space of the device, slave end of the link
`timescale 1ns/1ns
module cfg_space_dev #(
  parameter logic [31:0] DIRECT_BOOT_ADDR = 32'h0200_0000 // arbitrary value
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // link
  cfg_link_if.slave link,
  // straps and peripheral activity
  input wire logic [3:0] boot_select,
  input wire logic quick_boot_select,
  input wire logic [7:0] periph_active,
  // configuration outputs
  output logic boot_done,
  output logic [31:0] clk_setting,
  output logic eth_in_reset,
  output logic [31:0] pin_function_select_0,
  output logic [31:0] pin_function_select_1,
  output logic [31:0] io_power_down_control,
  output logic [31:0] host_port_control,
  output logic [31:0] timer_control,
  output logic [31:0] dma_transfer_ctrl_config,
  output logic [31:0] power_enable,
  output logic [31:0] master_priority_0,
  output logic [31:0] master_priority_1,
  output logic [31:0] dma_queue_priority,
  output logic [31:0] core_dma_arb_priority,
  output logic [4:0] program_cache_kb,
  output logic pcache_busy,
  output logic [31:0] mem_burst_priority,
  output logic [31:0] core_boot_address
);
  localparam int N = init_seq_pkg::NUM_REGS;

  logic [31:0] regs_reg [0:N-1];
  logic [31:0] regs_next [0:N-1];
  logic aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next, ar_hold_reg, ar_hold_next;
  logic [7:0] aw_addr_reg, aw_addr_next, ar_addr_reg, ar_addr_next;
  logic [31:0] w_data_reg, w_data_next;
  logic [3:0] w_strb_reg, w_strb_next;
  logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [7:0] chg_cnt_reg, chg_cnt_next;
  logic [7:0] boot_cnt_reg, boot_cnt_next;
  logic [3:0] strap_reg, strap_next;
  logic quick_reg, quick_next, strap_taken_reg, strap_taken_next;

  function automatic logic [31:0] reset_value(input int idx);
    if (idx == int'(init_seq_pkg::OFS_CLK_CTRL[6:2])) return init_seq_pkg::RST_CLK_CTRL;
    if (idx == int'(init_seq_pkg::OFS_IO_PWDN[6:2])) return init_seq_pkg::RST_IO_PWDN;
    return init_seq_pkg::RST_ZERO;
  endfunction : reset_value

  function automatic logic mapped(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a[7] == 1'b0) && (int'(a[6:2]) < N);
  endfunction : mapped

  function automatic logic writable(input logic [7:0] a);
    return mapped(a) && (a != init_seq_pkg::OFS_BOOT_STATUS) && (a != init_seq_pkg::OFS_ACTIVITY);
  endfunction : writable

  assign link.awready = !aw_hold_reg && !bvalid_reg;
  assign link.wready = !w_hold_reg && !bvalid_reg;
  assign link.arready = !ar_hold_reg && !rvalid_reg;
  assign link.bvalid = bvalid_reg;
  assign link.bresp = bresp_reg;
  assign link.rvalid = rvalid_reg;
  assign link.rdata = rdata_reg;
  assign link.rresp = rresp_reg;

  always_comb begin
    logic [4:0] idx;
    logic [31:0] merged;
    idx = aw_addr_reg[6:2];
    merged = regs_reg[idx];
    for (int i = 0; i < N; i++) begin
      regs_next[i] = regs_reg[i];
    end
    aw_hold_next = aw_hold_reg;
    aw_addr_next = aw_addr_reg;
    w_hold_next = w_hold_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    ar_hold_next = ar_hold_reg;
    ar_addr_next = ar_addr_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    chg_cnt_next = (chg_cnt_reg != 8'h00) ? chg_cnt_reg - 8'h01 : chg_cnt_reg;
    boot_cnt_next = (boot_cnt_reg != 8'h00) ? boot_cnt_reg - 8'h01 : boot_cnt_reg;
    strap_next = strap_reg;
    quick_next = quick_reg;
    strap_taken_next = 1'b1;
    // straps are caught on the first edge after reset release
    if (!strap_taken_reg) begin
      strap_next = boot_select;
      quick_next = quick_boot_select;
    end
    // address and data are taken in either order
    if (link.awvalid && link.awready) begin
      aw_hold_next = 1'b1;
      aw_addr_next = link.awaddr;
    end
    if (link.wvalid && link.wready) begin
      w_hold_next = 1'b1;
      w_data_next = link.wdata;
      w_strb_next = link.wstrb;
    end
    if (link.arvalid && link.arready) begin
      ar_hold_next = 1'b1;
      ar_addr_next = link.araddr;
    end
    // master priorities are taken whatever the power enable state
    if (aw_hold_reg && w_hold_reg && !bvalid_reg) begin
      aw_hold_next = 1'b0;
      w_hold_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = init_seq_pkg::RESP_SLVERR;
      if (writable(aw_addr_reg)) begin
        for (int b = 0; b < 4; b++) begin
          if (w_strb_reg[b]) merged[b*8 +: 8] = w_data_reg[b*8 +: 8];
        end
        regs_next[idx] = merged;
        bresp_next = init_seq_pkg::RESP_OKAY;
        if (aw_addr_reg == init_seq_pkg::OFS_PCACHE_CFG) begin
          chg_cnt_next = 8'(init_seq_pkg::PCACHE_CHG_CYCLES);
        end
      end
    end
    if (bvalid_reg && link.bready) bvalid_next = 1'b0;
    // a read of the program cache config waits for the mode change
    if (ar_hold_reg && !rvalid_reg &&
        !(ar_addr_reg == init_seq_pkg::OFS_PCACHE_CFG && chg_cnt_reg != 8'h00)) begin
      ar_hold_next = 1'b0;
      rvalid_next = 1'b1;
      rresp_next = mapped(ar_addr_reg) ? init_seq_pkg::RESP_OKAY : init_seq_pkg::RESP_SLVERR;
      if (!mapped(ar_addr_reg)) rdata_next = 32'h0000_0000;
      else if (ar_addr_reg == init_seq_pkg::OFS_BOOT_STATUS) rdata_next = {31'h0, boot_done};
      else if (ar_addr_reg == init_seq_pkg::OFS_ACTIVITY) rdata_next = {24'h0, periph_active};
      else if (ar_addr_reg == init_seq_pkg::OFS_BOOT_ADDR) rdata_next = core_boot_address;
      else rdata_next = regs_reg[ar_addr_reg[6:2]];
    end
    if (rvalid_reg && link.rready) rvalid_next = 1'b0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // all cache modes come out of boot at zero, memory acts as RAM
      for (int i = 0; i < N; i++) begin
        regs_reg[i] <= reset_value(i);
      end
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_hold_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      ar_hold_reg <= 1'b0;
      ar_addr_reg <= 8'h00;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
      rvalid_reg <= 1'b0;
      rresp_reg <= 2'h0;
      rdata_reg <= 32'h0000_0000;
      chg_cnt_reg <= 8'h00;
      boot_cnt_reg <= 8'(init_seq_pkg::BOOT_CYCLES);
      strap_reg <= 4'h0;
      quick_reg <= 1'b0;
      strap_taken_reg <= 1'b0;
    end else begin
      for (int i = 0; i < N; i++) begin
        regs_reg[i] <= regs_next[i];
      end
      aw_hold_reg <= aw_hold_next;
      aw_addr_reg <= aw_addr_next;
      w_hold_reg <= w_hold_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      ar_hold_reg <= ar_hold_next;
      ar_addr_reg <= ar_addr_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
      chg_cnt_reg <= chg_cnt_next;
      boot_cnt_reg <= boot_cnt_next;
      strap_reg <= strap_next;
      quick_reg <= quick_next;
      strap_taken_reg <= strap_taken_next;
    end
  end

  assign boot_done = (boot_cnt_reg == 8'h00);
  assign pcache_busy = (chg_cnt_reg != 8'h00);
  assign clk_setting = regs_reg[init_seq_pkg::OFS_CLK_CTRL[6:2]];
  assign eth_in_reset = regs_reg[init_seq_pkg::OFS_ETH_RESET[6:2]][0];
  assign pin_function_select_0 = regs_reg[init_seq_pkg::OFS_PIN_SEL0[6:2]];
  assign pin_function_select_1 = regs_reg[init_seq_pkg::OFS_PIN_SEL1[6:2]];
  assign io_power_down_control = regs_reg[init_seq_pkg::OFS_IO_PWDN[6:2]];
  assign host_port_control = regs_reg[init_seq_pkg::OFS_HOST_PORT[6:2]];
  assign timer_control = regs_reg[init_seq_pkg::OFS_TIMER[6:2]];
  assign dma_transfer_ctrl_config = regs_reg[init_seq_pkg::OFS_DMA_TC_CFG[6:2]];
  assign power_enable = regs_reg[init_seq_pkg::OFS_PWR_ENABLE[6:2]];
  assign master_priority_0 = regs_reg[init_seq_pkg::OFS_MST_PRI0[6:2]];
  assign master_priority_1 = regs_reg[init_seq_pkg::OFS_MST_PRI1[6:2]];
  assign dma_queue_priority = regs_reg[init_seq_pkg::OFS_DMA_QUE_PRI[6:2]];
  assign core_dma_arb_priority = regs_reg[init_seq_pkg::OFS_CORE_ARB[6:2]];
  assign mem_burst_priority = regs_reg[init_seq_pkg::OFS_MEM_BURST[6:2]];
  // mode 0 off, 1/2/3 give 4/8/16 kB
  always_comb begin
    unique case (regs_reg[init_seq_pkg::OFS_PCACHE_CFG[6:2]][init_seq_pkg::PCACHE_MODE_LSB +: 2])
      2'h0: program_cache_kb = 5'h00;
      2'h1: program_cache_kb = 5'h04;
      2'h2: program_cache_kb = 5'h08;
      2'h3: program_cache_kb = 5'h10;
    endcase
  end
  // direct boot without quick boot keeps its own start address
  assign core_boot_address = (strap_reg == init_seq_pkg::BOOT_DIRECT_MODE && !quick_reg) ?
                             DIRECT_BOOT_ADDR : init_seq_pkg::BOOT_DEFAULT_ADDR;
endmodule : cfg_space_dev

// ===== sim/init_seq_monitor.sv
// link protocol checker for the init sequencer link
`timescale 1ns/1ns
module init_seq_monitor (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write channels
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  // read channels
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [7:0] araddr,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence rd_taken;
    arvalid && arready && araddr != init_seq_pkg::OFS_PCACHE_CFG;
  endsequence
  sequence pc_write;
    awvalid && awready && awaddr == init_seq_pkg::OFS_PCACHE_CFG;
  endsequence
  aw_hold_a: assert property (awvalid && !awready |=> awvalid && $stable(awaddr))
    else $error("write address dropped before taken");
  w_hold_a: assert property (wvalid && !wready |=> wvalid && $stable(wdata))
    else $error("write data dropped before taken");
  write_answer_a: assert property (wr_taken |-> ##[1:2] bvalid)
    else $error("write response late");
  read_answer_a: assert property (rd_taken |-> ##[1:2] rvalid)
    else $error("read data late");
  b_stand_a: assert property (bvalid && bready |=> !bvalid)
    else $error("write response repeated");
  r_stand_a: assert property (rvalid && rready |=> !rvalid)
    else $error("read data repeated");
  pc_stall_a: assert property (pc_write |-> (!rvalid)[*8])
    else $error("cache config read not stalled");
  ack_first_a: assert property (bvalid |-> !awvalid && !arvalid)
    else $error("new request before write acknowledged");
  one_op_a: assert property (!(awvalid && arvalid))
    else $error("write and read together");
  full_strobe_a: assert property (wvalid |-> wstrb == 4'hf)
    else $error("partial write strobe");
  no_dma_cfg_a: assert property (awvalid |-> awaddr != init_seq_pkg::OFS_DMA_TC_CFG)
    else $error("dma transfer config written");
endmodule : init_seq_monitor

// ===== sim/tb.sv
// self-checking bench for the init sequencer and configuration space
`timescale 1ns/1ns
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin mismatches++; \
  $display("wrong value at %0t: got %h exp %h", $time, (a), (e)); end end
module tb;
  typedef struct {logic [31:0] clk; logic eth; logic hp; logic tm;
    logic [1:0] pm; logic [3:0] bs; logic [4:0] kb;} row_s;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic start = 1'b0;
  logic [31:0] desired_clk = 32'h1;
  logic [31:0] pat = 32'h0;
  logic use_ethernet = 1'b0;
  logic host_port_en = 1'b0;
  logic timer_en = 1'b0;
  logic [1:0] pcache_mode = 2'h0;
  logic [3:0] boot_select = 4'h0;
  logic quick_boot = 1'b0;
  logic [7:0] periph_active = 8'h0;
  logic busy, done, bus_error, boot_done, eth_rst, pc_busy;
  logic [4:0] step, kb;
  logic [31:0] clk_q, pf0, pf1, iop, hpq, tmq, dtc, pe, mp0, mp1, dqp, cap, mbp, baddr;
  int mismatches = 0;
  int cmp_count = 0;
  row_s rows [4] = '{'{32'h1, 1'b0, 1'b0, 1'b0, 2'h0, 4'h4, 5'h0}, '{32'h3, 1'b1, 1'b1, 1'b0, 2'h1, 4'h0, 5'h4},
    '{32'h5, 1'b0, 1'b0, 1'b1, 2'h2, 4'h1, 5'h8}, '{32'h1, 1'b1, 1'b1, 1'b1, 2'h3, 4'h4, 5'h10}};
  cfg_link_if link ();
  post_reset_init_sequencer i_post_reset_init_sequencer (.aclk(aclk), .aresetn(aresetn), .link(link.master),
    .start(start), .desired_clk(desired_clk), .use_ethernet(use_ethernet), .pin_sel0(pat), .pin_sel1(~pat),
    .io_pwdn(pat ^ 32'hff), .host_port_en(host_port_en), .host_port_val(pat + 32'h1), .timer_en(timer_en),
    .timer_val(pat + 32'h2), .power_enable_val(pat + 32'h3), .mst_pri0(pat + 32'h4), .mst_pri1(pat + 32'h5),
    .que_pri(pat + 32'h6), .core_arb_pri(pat + 32'h7), .pcache_mode(pcache_mode), .busy(busy), .done(done),
    .bus_error(bus_error), .step(step));
  cfg_space_dev i_cfg_space_dev (.aclk(aclk), .aresetn(aresetn), .link(link.slave), .boot_select(boot_select),
    .quick_boot_select(quick_boot), .periph_active(periph_active), .boot_done(boot_done), .clk_setting(clk_q),
    .eth_in_reset(eth_rst), .pin_function_select_0(pf0), .pin_function_select_1(pf1), .io_power_down_control(iop),
    .host_port_control(hpq), .timer_control(tmq), .dma_transfer_ctrl_config(dtc), .power_enable(pe),
    .master_priority_0(mp0), .master_priority_1(mp1), .dma_queue_priority(dqp), .core_dma_arb_priority(cap),
    .program_cache_kb(kb), .pcache_busy(pc_busy), .mem_burst_priority(mbp), .core_boot_address(baddr));
  init_seq_monitor i_init_seq_monitor (.aclk(aclk), .aresetn(aresetn), .awvalid(link.awvalid),
    .awready(link.awready), .awaddr(link.awaddr), .wvalid(link.wvalid), .wready(link.wready), .wdata(link.wdata),
    .wstrb(link.wstrb), .bvalid(link.bvalid), .bready(link.bready), .bresp(link.bresp), .arvalid(link.arvalid),
    .arready(link.arready), .araddr(link.araddr), .rvalid(link.rvalid), .rready(link.rready), .rdata(link.rdata));
  initial begin
    forever #20 aclk = ~aclk;
  end
  task automatic reset_dut();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
  endtask : reset_dut
  task automatic kick();
    @(posedge aclk);
    start <= 1'b1;
    @(posedge aclk);
    start <= 1'b0;
  endtask : kick
  task automatic wait_done(input int lim);
    for (int n = 0; n < lim && done !== 1'b1; n++) @(negedge aclk);
    `CHK(done, 1'b1)
  endtask : wait_done
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    final_report();
  end
  initial begin
    for (int i = 0; i < 4; i++) begin
      @(posedge aclk);
      desired_clk <= rows[i].clk;
      use_ethernet <= rows[i].eth;
      host_port_en <= rows[i].hp;
      timer_en <= rows[i].tm;
      pcache_mode <= rows[i].pm;
      boot_select <= rows[i].bs;
      pat <= 32'h1357_0000 + 32'h100 * i;
      reset_dut();
      `CHK(kb, 5'h0)
      kick();
      wait_done(2000);
      `CHK(clk_q, rows[i].clk)
      `CHK(eth_rst, rows[i].eth)
      `CHK(pf0, pat)
      `CHK(pf1, ~pat)
      `CHK(iop, pat ^ 32'hff)
      `CHK(hpq, rows[i].hp ? pat + 32'h1 : 32'h0)
      `CHK(tmq, rows[i].tm ? pat + 32'h2 : 32'h0)
      `CHK(dtc, 32'h0)
      `CHK(mp0, pat + 32'h4)
      `CHK(mp1, pat + 32'h5)
      `CHK(dqp, pat + 32'h6)
      `CHK(cap, pat + 32'h7)
      `CHK(kb, rows[i].kb)
      `CHK(baddr, rows[i].bs == 4'h4 ? 32'h0200_0000 : init_seq_pkg::BOOT_DEFAULT_ADDR)
      `CHK(mbp[7:0], init_seq_pkg::OLD_COUNT_REC)
      `CHK(bus_error, 1'b0)
    end
    @(posedge aclk);
    periph_active <= 8'h10;
    quick_boot <= 1'b1;
    reset_dut();
    `CHK(busy, 1'b0)
    `CHK(boot_done, 1'b0)
    kick();
    repeat (30) @(negedge aclk);
    `CHK(step, 5'h0)
    repeat (300) @(negedge aclk);
    `CHK(step, 5'h7)
    `CHK(pe, 32'h0)
    @(posedge aclk);
    periph_active <= 8'h0;
    wait_done(2000);
    `CHK(pe, pat + 32'h3)
    `CHK(pc_busy, 1'b0)
    `CHK(baddr, init_seq_pkg::BOOT_DEFAULT_ADDR)
    final_report();
  end
endmodule : tb
